/* rtl/mic_edge_det.sv */
// Purpose: pin synchroniser and edge detector
// Assumes: pins are asynchronous to core_clk
// Notes: edge pulse is combinational on synchronised samples
`timescale 1ns/1ps
module mic_edge_det
  import mic_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] pin_n,
  input  wire logic [N-1:0] rise_sel,
  output logic      [N-1:0] edge_evt
);
  if (N < 1) begin : g_chk
    $error("mic_edge_det needs at least one pin");
  end
  logic [N-1:0] meta_q; // first stage, read by second only
  logic [N-1:0] sync_q; // safe sample
  logic [N-1:0] prev_q; // previous sample for comparison

  // pins idle high, so reset to ones avoids a false edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pin_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // per pin edge choice
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign edge_evt[i] = rise_sel[i] ? (sync_q[i] & ~prev_q[i]) // R07 R23
                                     : (~sync_q[i] & prev_q[i]);
  end
endmodule

/* rtl/mic_intc.sv */
// Purpose: interrupt controller with flags, priority and entry sequence
// Assumes: APB master on core_clk, cpu signals on core_clk
// Notes: pins pass two flip-flops before edge detection
`timescale 1ns/1ps
module mic_intc
  import mic_pkg::*;
#(
  parameter int N_WAKE = NUM_WAKE,
  parameter int N_EDGE = NUM_EDGE,
  parameter int N_INT  = NUM_INT
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_WAKE-1:0] wake_pin_n,
  input  wire logic [N_EDGE-1:0] edge_request_pin_n,
  input  wire logic [N_INT-1:0]  periph_evt,
  input  wire logic              cpu_instr_done,
  input  wire logic [15:0]       cpu_pc,
  input  wire logic [15:0]       vec_rdata,
  output logic                   irq_mask,
  output mic_entry_s             entry
);
  // layout is fixed by the register map
  if (N_WAKE != NUM_WAKE || N_EDGE != NUM_EDGE || N_INT != NUM_INT) // R04
  begin : g_chk
    $error("mic_intc source counts are fixed by the register map");
  end

  // register state
  logic [7:0]  wake_q;     // wakeup_request_flags
  logic [4:0]  edge_q;     // edge request flags
  logic [19:0] int_q;      // internal request flags
  logic [5:0]  en1_q;      // edge enables plus wake group
  logic [19:0] en_int_q;   // internal enables
  logic [4:0]  esel_q;     // edge_select_register
  logic [12:0] pmode_q;    // wake and edge pin modes
  logic [7:0]  ccr_q;      // condition_code_register
  logic [31:0] prdata_q;   // read data held for access phase

  // entry sequencer
  mic_state_e  state_q;
  logic [1:0]  cnt_q;      // cycles spent in a timed phase
  logic [4:0]  vec_q;      // accepted vector
  logic [15:0] ret_pc_q;
  logic [7:0]  sccr_q;
  logic [15:0] handler_q;
  logic        hvld_q;     // jump pulse

  // bus decode
  logic wr;
  logic rd_setup;
  logic hit_wake;
  logic hit_req1;
  logic hit_reqint;
  logic hit_en1;
  logic hit_enint;
  logic hit_edge;
  logic hit_pmode;
  logic hit_ccr;
  logic hit_stat;
  logic hit_any;

  assign hit_wake   = (paddr == OFS_WAKE);
  assign hit_req1   = (paddr == OFS_REQ1);
  assign hit_reqint = (paddr == OFS_REQINT);
  assign hit_en1    = (paddr == OFS_EN1);
  assign hit_enint  = (paddr == OFS_ENINT);
  assign hit_edge   = (paddr == OFS_EDGE);
  assign hit_pmode  = (paddr == OFS_PMODE);
  assign hit_ccr    = (paddr == OFS_CCR);
  assign hit_stat   = (paddr == OFS_STAT);
  assign hit_any    = hit_wake | hit_req1 | hit_reqint | hit_en1 | hit_enint
                    | hit_edge | hit_pmode | hit_ccr | hit_stat;
  assign wr         = psel & penable & pwrite & hit_any;
  assign rd_setup   = psel & ~penable & ~pwrite;

  // zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  // pin edge detection, wake pins fixed to falling edge
  logic [7:0] wake_evt;
  logic [4:0] edge_evt;

  mic_edge_det #(.N(N_WAKE)) u_wake_det (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_n    (wake_pin_n),
    .rise_sel ('0),
    .edge_evt (wake_evt)
  );

  mic_edge_det #(.N(N_EDGE)) u_edge_det (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_n    (edge_request_pin_n),
    .rise_sel (esel_q),
    .edge_evt (edge_evt)
  );

  // events that reach a flag: enable required, pin mode too for wake and edge pins
  logic [7:0]  wake_set;
  logic [4:0]  edge_set;
  logic [19:0] int_set;
  assign wake_set = wake_evt & pmode_q[7:0]
                  & {8{en1_q[EN1_WAKE_BIT]}}; // R01 R05 R14
  assign edge_set = edge_evt & pmode_q[12:PMODE_EDGE_LO]
                  & en1_q[4:0];               // R08 R09 R14
  assign int_set  = periph_evt & en_int_q;    // R12 R14

  // sticky flags: write 0 clears, write 1 keeps, set beats clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_q <= RST_WAKE;
      edge_q <= '0;
      int_q  <= '0;
    end else begin
      wake_q <= (wr && hit_wake ? wake_q & pwdata[7:0] : wake_q)
              | wake_set;                      // R01 R02
      edge_q <= (wr && hit_req1 ? edge_q & pwdata[4:0] : edge_q)
              | edge_set;                      // R02 R08
      int_q  <= (wr && hit_reqint ? int_q & pwdata[19:0] : int_q)
              | int_set;                       // R02 R12
    end
  end

  // plain configuration registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en1_q    <= '0;
      en_int_q <= '0;
      esel_q   <= '0;
      pmode_q  <= '0;
    end else if (wr) begin
      if (hit_en1)   en1_q    <= pwdata[5:0];
      if (hit_enint) en_int_q <= pwdata[19:0];
      if (hit_edge)  esel_q   <= pwdata[4:0];   // R07
      if (hit_pmode) pmode_q  <= pwdata[12:0];
    end
  end

  // priority over enabled pending flags; wake group is one slot
  logic [NUM_PRI-1:0] pend;
  logic               pend_any;
  logic [4:0]         pend_idx;
  assign pend = {int_q & en_int_q,
                 (|wake_q) & en1_q[EN1_WAKE_BIT],  // R05 R06
                 edge_q & en1_q[4:0]};              // R09

  mic_prio_enc #(.N(NUM_PRI)) u_prio (
    .req (pend),
    .any (pend_any),
    .idx (pend_idx)
  );

  // a clearing write in flight holds off acceptance until it lands
  logic conflict;
  logic accept;
  assign conflict = psel & pwrite
                  & (hit_wake | hit_req1 | hit_reqint | hit_en1 | hit_enint); // R22
  assign accept   = (state_q == ST_IDLE) & pend_any
                  & ~ccr_q[CCR_I_BIT] & ~conflict;   // R15 R16

  // mask bit: acceptance sets it and wins over a software write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_q <= RST_CCR;
    end else if (accept) begin
      ccr_q[CCR_I_BIT] <= 1'b1;                 // R18
    end else if (wr && hit_ccr) begin
      ccr_q <= pwdata[7:0];
    end
  end
  assign irq_mask = ccr_q[CCR_I_BIT];

  // phase length of timed states
  logic [1:0] last_cnt;
  always_comb begin
    case (state_q)
      ST_STACK:   last_cnt = 2'(STACK_STATES * STATE_CYC - 1);  // R20
      ST_VFETCH:  last_cnt = 2'(VFETCH_STATES * STATE_CYC - 1); // R20
      ST_IFETCH:  last_cnt = 2'(IFETCH_STATES * STATE_CYC - 1); // R20
      ST_INTPROC: last_cnt = 2'(INTPROC_STATES * STATE_CYC - 1);
      default:    last_cnt = 2'h0;
    endcase
  end

  // entry sequence; flags stay untouched all the way through
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) state_q <= ST_WAIT;         // R03
        end
        ST_WAIT: begin
          // cpu finishes the current instruction first
          if (cpu_instr_done) state_q <= ST_STACK; // R17
        end
        ST_STACK, ST_VFETCH, ST_IFETCH, ST_INTPROC: begin
          if (cnt_q == last_cnt) begin
            cnt_q <= 2'h0;
            case (state_q)
              ST_STACK:  state_q <= ST_VFETCH;     // R19
              ST_VFETCH: state_q <= ST_IFETCH;
              ST_IFETCH: state_q <= ST_INTPROC;
              default:   state_q <= ST_IDLE;
            endcase
          end else begin
            cnt_q <= 2'(cnt_q + 2'h1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= 2'h0;
        end
      endcase
    end
  end

  // captured entry data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_q     <= 5'h00;
      ret_pc_q  <= RST_WORD;
      sccr_q    <= 8'h00;
      handler_q <= RST_WORD;
      hvld_q    <= 1'b0;
    end else begin
      hvld_q <= 1'b0;
      if (accept) begin
        vec_q  <= mic_vec_of(pend_idx);          // R06 R10 R13
        sccr_q <= ccr_q;                          // pre-mask value
      end
      if (state_q == ST_WAIT && cpu_instr_done)
        ret_pc_q <= cpu_pc;                       // R17
      if (state_q == ST_VFETCH && cnt_q == last_cnt) begin
        handler_q <= vec_rdata;                   // R19
        hvld_q    <= 1'b1;
      end
    end
  end

  // word vectors: byte address is twice the vector number
  always_comb begin
    entry             = '0;
    entry.active      = (state_q != ST_IDLE);
    entry.stack_en    = (state_q == ST_STACK);    // R17
    entry.vec_en      = (state_q == ST_VFETCH);   // R19
    entry.handler_vld = hvld_q;
    entry.vector      = vec_q;
    entry.vec_addr    = {10'h000, vec_q, 1'b0};
    entry.ret_pc      = ret_pc_q;
    entry.saved_ccr   = sccr_q;
    entry.handler     = handler_q;
  end

  // read data captured in the setup cycle, reserved bit reads one
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= 32'h0000_0000;
      if (hit_wake)   prdata_q[7:0]  <= wake_q;
      if (hit_req1)   prdata_q[7:0]  <= {2'b00, 1'b1, edge_q};
      if (hit_reqint) prdata_q[19:0] <= int_q;
      if (hit_en1)    prdata_q[5:0]  <= en1_q;
      if (hit_enint)  prdata_q[19:0] <= en_int_q;
      if (hit_edge)   prdata_q[4:0]  <= esel_q;
      if (hit_pmode)  prdata_q[12:0] <= pmode_q;
      if (hit_ccr)    prdata_q[7:0]  <= ccr_q;
      if (hit_stat)   prdata_q[8:0]  <= {entry.active, state_q, vec_q[4:0]};
    end
  end

  // checks
  property p_wake_set;
    @(posedge core_clk) disable iff (sys_rst)
    (|wake_set) |=> ((wake_q & $past(wake_set)) == $past(wake_set));
  endproperty
  a_wake_set: assert property (p_wake_set) // R01
    else $error("wake flag missed its edge");

  property p_clear_only_write;
    @(posedge core_clk) disable iff (sys_rst)
    (|($past(wake_q) & ~wake_q)) |-> $past(wr && hit_wake && pwdata[7:0] != 8'hff);
  endproperty
  a_clear_only_write: assert property (p_clear_only_write) // R02
    else $error("wake flag fell without a clearing write");

  property p_sticky_accept;
    @(posedge core_clk) disable iff (sys_rst)
    (accept && !wr) |=> ((edge_q & $past(edge_q)) == $past(edge_q))
                        && ((int_q & $past(int_q)) == $past(int_q))
                        && ((wake_q & $past(wake_q)) == $past(wake_q));
  endproperty
  a_sticky_accept: assert property (p_sticky_accept) // R03
    else $error("acceptance cleared a flag");

  property p_accept_unmasked;
    @(posedge core_clk) disable iff (sys_rst)
    accept |-> !irq_mask ##1 irq_mask;
  endproperty
  a_accept_unmasked: assert property (p_accept_unmasked) // R16
    else $error("accept with mask set or mask not raised");

  property p_mask_holds;
    @(posedge core_clk) disable iff (sys_rst)
    accept |=> irq_mask && state_q == ST_WAIT;
  endproperty
  a_mask_holds: assert property (p_mask_holds) // R18
    else $error("mask bit not set on acceptance");

  property p_edge0_first;
    @(posedge core_clk) disable iff (sys_rst)
    (accept && pend[0]) |=> vec_q == VEC_EDGE_BASE;
  endproperty
  a_edge0_first: assert property (p_edge0_first) // R11
    else $error("edge pin zero lost priority");

  property p_wake_vector;
    @(posedge core_clk) disable iff (sys_rst)
    (accept && pend_idx == PRI_WAKE) |=> vec_q == VEC_WAKE;
  endproperty
  a_wake_vector: assert property (p_wake_vector) // R06
    else $error("wake vector wrong");

  property p_conflict_holds;
    @(posedge core_clk) disable iff (sys_rst)
    (conflict && state_q == ST_IDLE) |=> state_q == ST_IDLE;
  endproperty
  a_conflict_holds: assert property (p_conflict_holds) // R22
    else $error("accepted during a clearing write");

  property p_entry_timing;
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == ST_WAIT && cpu_instr_done) |=>
      (state_q == ST_STACK)[*4] ##1 (state_q == ST_VFETCH)[*2]
      ##1 (state_q == ST_IFETCH)[*4] ##1 (state_q == ST_INTPROC)[*4]
      ##1 (state_q == ST_IDLE);
  endproperty
  a_entry_timing: assert property (p_entry_timing) // R20
    else $error("entry phase lengths wrong");

  property p_handler_jump;
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == ST_VFETCH && cnt_q == 2'h1) |=>
      hvld_q && handler_q == $past(vec_rdata) && state_q == ST_IFETCH;
  endproperty
  a_handler_jump: assert property (p_handler_jump) // R19
    else $error("handler address not taken at vector fetch end");
endmodule

/* rtl/mic_pkg.sv */
// Purpose: shared constants and types of the interrupt controller
// Assumes: one 200 MHz clock, registers reached over APB
// Notes: offsets are byte addresses, one 32-bit word per register
// Function
// R01: wake pin falling edge sets its flag
// R02: write 0 clears flag, 1 keeps
// R03: acceptance leaves request flags set
// R04: thirteen external sources, eight wake, five edge
// R05: one group enable gates all wake requests
// R06: all wake sources share vector nine
// R07: per pin edge select, rising or falling
// R08: configured edge pin sets its request flag
// R09: each edge request has own enable
// R10: edge requests use vectors four to eight
// R11: edge pin zero highest, pin four lowest
// R12: twenty internal requests, own flag and enable
// R13: internal requests use vectors ten to twenty
// R14: flag records request only while enabled
// R15: highest priority pending wins, others wait
// R16: accept only while global mask clear
// R17: stack return address and condition codes
// R18: acceptance sets the global mask bit
// R19: fetch vector, then jump to handler
// R20: entry phases take fixed state counts
// R21: software clears only while masked
// R22: clearing write delays conflicting acceptance
// R23: sampled edge sets flag next cycle
package mic_pkg;
  localparam int NUM_WAKE = 8;               // wake pins
  localparam int NUM_EDGE = 5;               // edge-selectable pins
  localparam int NUM_INT  = 20;              // internal peripheral requests
  localparam int NUM_PRI  = NUM_EDGE + 1 + NUM_INT; // wake group is one slot
  // register byte offsets
  localparam logic [11:0] OFS_WAKE   = 12'h000; // wakeup_request_flags
  localparam logic [11:0] OFS_REQ1   = 12'h004; // request_register_one
  localparam logic [11:0] OFS_REQINT = 12'h008; // internal request flags
  localparam logic [11:0] OFS_EN1    = 12'h00c; // enable_register_one
  localparam logic [11:0] OFS_ENINT  = 12'h010; // internal enables
  localparam logic [11:0] OFS_EDGE   = 12'h014; // edge_select_register
  localparam logic [11:0] OFS_PMODE  = 12'h018; // pin modes, wake and edge
  localparam logic [11:0] OFS_CCR    = 12'h01c; // condition_code_register
  localparam logic [11:0] OFS_STAT   = 12'h020; // entry status, read only
  // field positions
  localparam int EN1_WAKE_BIT  = 5;          // wake_group_enable
  localparam int REQ1_RSV_BIT  = 5;          // reserved, reads one
  localparam int PMODE_EDGE_LO = 8;          // edge pin modes start here
  localparam int CCR_I_BIT     = 7;          // global mask bit
  // reset values
  localparam logic [7:0]  RST_WAKE  = 8'h00;
  localparam logic [7:0]  RST_CCR   = 8'h80; // masked out of reset
  localparam logic [15:0] RST_WORD  = 16'h0000;
  // vectors and priority slots
  localparam logic [4:0] VEC_EDGE_BASE = 5'h04;
  localparam logic [4:0] VEC_WAKE      = 5'h09;
  localparam logic [4:0] VEC_INT_BASE  = 5'h0a;
  localparam logic [4:0] VEC_INT_LAST  = 5'h14;
  localparam logic [4:0] PRI_WAKE      = 5'h05;
  localparam logic [4:0] PRI_INT_BASE  = 5'h06;
  localparam logic [4:0] PRI_LAST      = 5'h19;
  // entry timing, in cpu states; one state is one core_clk cycle
  localparam int STATE_NS     = 5;           // state time in ns
  localparam int CLK_MHZ      = 200;
  localparam int STATE_CYC    = (STATE_NS * CLK_MHZ + 999) / 1000;
  localparam int STACK_STATES = 4;
  localparam int VFETCH_STATES = 2;
  localparam int IFETCH_STATES = 4;
  localparam int INTPROC_STATES = 4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WAIT    = 3'b001,
    ST_STACK   = 3'b010,
    ST_VFETCH  = 3'b011,
    ST_IFETCH  = 3'b100,
    ST_INTPROC = 3'b101
  } mic_state_e;

  typedef struct packed {
    logic        active;     // entry sequence running
    logic        stack_en;   // pushing return pc and ccr
    logic        vec_en;     // vector table read
    logic        handler_vld;// one-cycle jump pulse
    logic [4:0]  vector;     // accepted vector number
    logic [15:0] vec_addr;   // vector table byte address
    logic [15:0] ret_pc;     // stacked program_counter
    logic [7:0]  saved_ccr;  // stacked condition codes
    logic [15:0] handler;    // handler start address
  } mic_entry_s;

  // priority slot to vector number
  function automatic logic [4:0] mic_vec_of(input logic [4:0] idx);
    logic [4:0] off;
    off = 5'(idx - PRI_INT_BASE);
    if (idx < PRI_WAKE) mic_vec_of = 5'(idx + VEC_EDGE_BASE);
    else if (idx == PRI_WAKE) mic_vec_of = VEC_WAKE;
    else if (idx == PRI_LAST) mic_vec_of = VEC_INT_LAST;
    else mic_vec_of = 5'(VEC_INT_BASE + (off >> 1));
  endfunction
endpackage

/* rtl/mic_prio_enc.sv */
// Purpose: fixed priority picker, slot zero highest
// Assumes: requests already gated by enables
// Notes: purely combinational
`timescale 1ns/1ps
module mic_prio_enc
  import mic_pkg::*;
#(
  parameter int N = NUM_PRI
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [4:0]        idx
);
  if (N > 32 || N < 1) begin : g_chk
    $error("mic_prio_enc supports 1 to 32 slots");
  end
  // scan from lowest priority up so the lowest slot wins
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i); // R11 R15
      end
    end
  end
endmodule

/* testbench/mcu_interrupt_controller_test.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: zero wait APB slave, cpu model answers entries
// Notes: flags are cleared only while masked
`timescale 1ns/1ps
module mcu_interrupt_controller_test
  import mic_pkg::*;
;
  localparam logic [15:0] RET_PC = 16'h3a5c; // model's return address
  logic        core_clk, sys_rst, psel, penable, pwrite, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, m;
  logic        pready, pslverr, cpu_instr_done, irq_mask, err;
  logic [7:0]  wake_pin_n;
  logic [4:0]  edge_request_pin_n;
  logic [19:0] periph_evt;
  logic [15:0] cpu_pc, vec_rdata;
  mic_entry_s  entry;
  int          n_fail, cmp_count, cycles;

  mic_intc u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wake_pin_n, .edge_request_pin_n, .periph_evt,
    .cpu_instr_done, .cpu_pc, .vec_rdata, .irq_mask, .entry);
  mic_cpu_model #(.RET_PC(RET_PC)) u_cpu (.core_clk, .sys_rst, .slow, .entry,
    .cpu_instr_done, .cpu_pc, .vec_rdata);

  // clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready seen, only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // unmask, then follow one whole entry sequence
  task automatic run_entry(input logic [4:0] v, input logic s);
    int k = 0;
    int n_st = 0;
    int n_ve = 0;
    int n_hv = 0;
    slow <= s;
    apb(1'b1, OFS_CCR, 32'h0);
    while (entry.active !== 1'b1 && k < 10) begin
      @(posedge core_clk);
      k++;
    end
    check(entry.vector, v);
    check(irq_mask, 1'b1);
    check(entry.saved_ccr, 8'h00);
    for (k = 0; k < 60 && entry.active === 1'b1; k++) begin
      if (entry.stack_en === 1'b1) n_st++;
      if (entry.vec_en === 1'b1) n_ve++;
      if (entry.handler_vld === 1'b1) begin
        n_hv++;
        check(entry.handler, {8'ha5, 2'b00, v, 1'b0});
        check(entry.ret_pc, RET_PC);
      end
      @(posedge core_clk);
    end
    check(n_st, 4);
    check(n_ve, 2);
    check(n_hv, 1);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, run needs under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {sys_rst, psel, penable, pwrite, slow} = 5'h10;
    {paddr, pwdata, periph_evt} = '0;
    wake_pin_n = 8'hff;
    edge_request_pin_n = 5'h1f;
    {n_fail, cmp_count, cycles} = '0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rd_chk(OFS_WAKE, 32'h0);
    rd_chk(OFS_REQ1, 32'h20);
    rd_chk(OFS_CCR, 32'h80);
    apb(1'b0, 12'h0fc, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("test reset done");
    // wake flags: gated, set by falls, cleared by zeros
    apb(1'b1, OFS_PMODE, 32'h1fff);
    wake_pin_n <= 8'hf7;
    idle(8);
    rd_chk(OFS_WAKE, 32'h0);
    wake_pin_n <= 8'hff;
    apb(1'b1, OFS_EN1, 32'h20);
    wake_pin_n <= 8'h7e;
    idle(8);
    rd_chk(OFS_WAKE, 32'h81);
    apb(1'b1, OFS_WAKE, 32'hff);
    rd_chk(OFS_WAKE, 32'h81);
    apb(1'b1, OFS_WAKE, 32'h7f);
    rd_chk(OFS_WAKE, 32'h01);
    wake_pin_n <= 8'hff;
    apb(1'b1, OFS_WAKE, 32'h0);
    $display("test wake done");
    // edge pins: pin0 disabled, pins 1 and 3 on rising edge
    apb(1'b1, OFS_EN1, 32'h1e);
    apb(1'b1, OFS_EDGE, 32'h0a);
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 32'h0 : 32'h1 << i;
      edge_request_pin_n[i] <= 1'b0;
      idle(8);
      rd_chk(OFS_REQ1, (i % 2 == 1) ? 32'h20 : 32'h20 | m);
      edge_request_pin_n[i] <= 1'b1;
      idle(8);
      rd_chk(OFS_REQ1, 32'h20 | m);
      apb(1'b1, OFS_REQ1, ~m);
    end
    rd_chk(OFS_REQ1, 32'h20);
    $display("test edge done");
    // priority, masking and entry
    apb(1'b1, OFS_EDGE, 32'h0);
    apb(1'b1, OFS_EN1, 32'h3f);
    edge_request_pin_n <= 5'h0a;
    wake_pin_n <= 8'hdf;
    idle(20);
    check(entry.active, 1'b0);
    rd_chk(OFS_REQ1, 32'h35);
    run_entry(5'h04, 1'b0);
    apb(1'b1, OFS_REQ1, 32'hfe);
    run_entry(5'h06, 1'b0);
    rd_chk(OFS_REQ1, 32'h34);
    apb(1'b1, OFS_REQ1, 32'hfb);
    run_entry(5'h08, 1'b1);
    apb(1'b1, OFS_REQ1, 32'hef);
    run_entry(5'h09, 1'b0);
    rd_chk(OFS_STAT, 32'h9);
    rd_chk(OFS_WAKE, 32'h20);
    apb(1'b1, OFS_WAKE, 32'h0);
    $display("test entry done");
    // internal sources, bit 5 left disabled
    apb(1'b1, OFS_ENINT, 32'h80001);
    periph_evt <= 20'h80021;
    @(posedge core_clk);
    periph_evt <= 20'h0;
    rd_chk(OFS_REQINT, 32'h80001);
    run_entry(5'h0a, 1'b1);
    apb(1'b1, OFS_REQINT, 32'hffffe);
    run_entry(5'h14, 1'b0);
    apb(1'b1, OFS_REQINT, 32'h0);
    rd_chk(OFS_REQINT, 32'h0);
    $display("test internal done");
    give_verdict();
  end
endmodule

/* testbench/mic_cpu_model.sv */
// Purpose: cpu core stand-in that answers the interrupt entry sequence
// Assumes: entry fields as the controller drives them on core_clk
// Notes: slow=1 stretches the running instruction to its longest wait
`timescale 1ns/1ps
module mic_cpu_model
  import mic_pkg::*;
#(
  parameter logic [15:0] RET_PC = 16'h3a5c // return address handed over
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire mic_entry_s entry,
  output logic            cpu_instr_done,
  output logic [15:0]     cpu_pc,
  output logic [15:0]     vec_rdata
);
  logic [3:0] wait_q; // states spent in the running instruction
  logic       done_q; // instruction already finished in this entry
  logic [15:0] tbl;   // vector table word for the current vector

  // count wait states, forget them once the entry is over
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!entry.active) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'h1;
      if (cpu_instr_done) done_q <= 1'b1;
    end
  end

  // one pulse after 0 or 12 wait states
  assign cpu_instr_done = entry.active && !done_q && (wait_q == (slow ? 4'hc : 4'h0));
  // pc only meaningful with the pulse, so show garbage otherwise
  assign cpu_pc = cpu_instr_done ? RET_PC : ~RET_PC;
  assign tbl = {8'ha5, entry.vec_addr[7:0]};
  // memory drives the table word only while it is read
  assign vec_rdata = entry.vec_en ? tbl : ~tbl;
endmodule
